// [design/afp_dc_detect.v]
// DC detect timer for one output channel
`timescale 1ns/100ps
`include "afp_defines.vh"
module afp_dc_detect #(
    parameter DC_CYCLES = `AFP_DC_CYCLES
) (
    input  wire                    mclk_i,
    input  wire                    rst_n_i,
    input  wire [`AFP_DUTY_W-1:0]  duty_pct_i,
    input  wire                    polarity_i,
    output reg                     dc_event_o
);
    // ==========================================================
    // Duty above limit at steady polarity
    reg  [31:0] count;
    reg         last_pol;
    wire        above = (duty_pct_i > `AFP_DUTY_LIMIT_PCT);

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count      <= 32'h0;
            last_pol   <= 1'b0;
            dc_event_o <= 1'b0;
        end else begin
            last_pol <= polarity_i;
            if (!above || polarity_i != last_pol) begin
                count      <= 32'h0;
                dc_event_o <= 1'b0;
            end else if (count >= DC_CYCLES) begin
                dc_event_o <= 1'b1;
            end else begin
                count <= count + 32'h1;
            end
        end
    end
endmodule

// [design/afp_defines.vh]
// Constants for the amplifier fault protection handler
`ifndef AFP_DEFINES_VH
`define AFP_DEFINES_VH
// ==========================================================
// Timing
`define AFP_CLK_HZ          10000000
`define AFP_DC_TIME_MS      420
`define AFP_DC_CYCLES       (`AFP_DC_TIME_MS * (`AFP_CLK_HZ / 1000))
`define AFP_TIMEOUT_CYCLES  10000
// ==========================================================
// Duty threshold and switching defaults
`define AFP_DUTY_LIMIT_PCT  60
`define AFP_SWFREQ_KHZ      768
`define AFP_DUTY_W          7
// ==========================================================
// Status bit positions and width
`define AFP_ST_OV           0
`define AFP_ST_UV           1
`define AFP_ST_CLK          2
`define AFP_ST_OC           3
`define AFP_ST_DC           4
`define AFP_ST_OT           5
`define AFP_ST_W            6
`endif

// [design/afp_fault_handler.v]
// Fault classification and fault line control for the amplifier
`timescale 1ns/100ps
`include "afp_defines.vh"
module afp_fault_handler #(
    parameter TIMEOUT_CYCLES = `AFP_TIMEOUT_CYCLES,
    parameter DC_CYCLES      = `AFP_DC_CYCLES
) (
    input  wire                   mclk_i,
    input  wire                   rst_n_i,
    input  wire                   hw_mode_select_i,
    input  wire                   amp_shutdown_n_i,
    input  wire                   sw_shutdown_n_i,
    input  wire                   sw_swfreq_half_i,
    input  wire                   hw_swfreq_half_i,
    input  wire                   supply_overvoltage_err_i,
    input  wire                   supply_undervoltage_err_i,
    input  wire                   clk_ratio_bad_i,
    input  wire                   clk_rate_bad_i,
    input  wire                   mclk_stopped_i,
    input  wire                   bclk_stopped_i,
    input  wire                   fclk_stopped_i,
    input  wire                   output_overcurrent_err_i,
    input  wire                   die_overtemp_err_i,
    input  wire                   overtemp_hysteresis_i,
    input  wire [`AFP_DUTY_W-1:0] duty_a_pct_i,
    input  wire                   pol_a_i,
    input  wire [`AFP_DUTY_W-1:0] duty_b_pct_i,
    input  wire                   pol_b_i,
    output reg                    amp_fault_n_o,
    output reg                    amp_fault_oe_o,
    output reg                    play_en_o,
    output reg                    swfreq_half_o,
    output reg  [`AFP_ST_W-1:0]   status_o
);
    // ==========================================================
    // States
    localparam [2:0] ST_RUN  = 3'b001;
    localparam [2:0] ST_LAT  = 3'b010;
    localparam [2:0] ST_WAIT = 3'b100;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [31:0] tmo;
    reg         tmo_done;
    reg         sd_lowseen;
    reg         oc_lat;
    reg         dc_lat;
    reg         ot_lat;
    wire [1:0]  dc_ch;

    // ==========================================================
    // DC detectors per channel
    wire [2*`AFP_DUTY_W-1:0] duty_all = {duty_b_pct_i, duty_a_pct_i};
    wire [1:0]               pol_all  = {pol_b_i, pol_a_i};
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_dc
            afp_dc_detect #(
                .DC_CYCLES (DC_CYCLES)
            ) u_dc (
                .mclk_i     (mclk_i),
                .rst_n_i    (rst_n_i),
                .duty_pct_i (duty_all[ch*`AFP_DUTY_W +: `AFP_DUTY_W]),
                .polarity_i (pol_all[ch]),
                .dc_event_o (dc_ch[ch])
            );
        end
    endgenerate

    // ==========================================================
    // Error classification
    wire shutdown_n = hw_mode_select_i ? amp_shutdown_n_i
                                       : (amp_shutdown_n_i & sw_shutdown_n_i);
    wire clk_err    = clk_ratio_bad_i | clk_rate_bad_i | mclk_stopped_i
                      | bclk_stopped_i | fclk_stopped_i;
    wire dc_raw     = |dc_ch;
    wire lat_raw    = output_overcurrent_err_i | dc_raw | die_overtemp_err_i;
    wire ot_cool    = ~die_overtemp_err_i & ~overtemp_hysteresis_i;
    wire can_clear  = tmo_done & sd_lowseen & ot_cool;
    // Line let go once recovery only waits for shutdown release
    wire line_free  = (next_state == ST_WAIT) & can_clear & ~lat_raw;

    // ==========================================================
    // Recovery state machine
    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (lat_raw && shutdown_n)
                    next_state = ST_LAT;
            end
            ST_LAT: begin
                if (!shutdown_n)
                    next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (shutdown_n && lat_raw)
                    next_state = ST_LAT;
                else if (shutdown_n && can_clear)
                    next_state = ST_RUN;
            end
            default: next_state = ST_RUN;
        endcase
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Fault timeout from fault entry
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmo      <= 32'h0;
            tmo_done <= 1'b0;
        end else if (state == ST_RUN) begin
            tmo      <= 32'h0;
            tmo_done <= 1'b0;
        end else if (tmo >= TIMEOUT_CYCLES - 1) begin
            tmo_done <= 1'b1;
        end else begin
            tmo <= tmo + 32'h1;
        end
    end

    // ==========================================================
    // Shutdown seen low since latch entry
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sd_lowseen <= 1'b0;
        end else if (next_state == ST_LAT) begin
            sd_lowseen <= 1'b0;
        end else if (!shutdown_n) begin
            sd_lowseen <= 1'b1;
        end
    end

    // ==========================================================
    // Latched causes, kept until back in run
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oc_lat <= 1'b0;
            dc_lat <= 1'b0;
            ot_lat <= 1'b0;
        end else if (next_state == ST_RUN) begin
            oc_lat <= 1'b0;
            dc_lat <= 1'b0;
            ot_lat <= 1'b0;
        end else begin
            oc_lat <= oc_lat | output_overcurrent_err_i;
            dc_lat <= dc_lat | dc_raw;
            ot_lat <= ot_lat | die_overtemp_err_i;
        end
    end

    // ==========================================================
    // Fault line and playback enable
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            amp_fault_n_o  <= 1'b1;
            amp_fault_oe_o <= 1'b0;
            play_en_o      <= 1'b0;
        end else begin
            amp_fault_n_o  <= 1'b0;
            amp_fault_oe_o <= ((next_state != ST_RUN) & ~line_free) | clk_err;
            play_en_o      <= (next_state == ST_RUN) & shutdown_n & ~clk_err
                              & ~supply_overvoltage_err_i
                              & ~supply_undervoltage_err_i;
        end
    end

    // ==========================================================
    // Switching frequency select
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            swfreq_half_o <= 1'b0;
        end else begin
            swfreq_half_o <= hw_mode_select_i ? hw_swfreq_half_i
                                              : sw_swfreq_half_i;
        end
    end

    // ==========================================================
    // Error status flags
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_o <= {`AFP_ST_W{1'b0}};
        end else begin
            status_o[`AFP_ST_OV]  <= supply_overvoltage_err_i;
            status_o[`AFP_ST_UV]  <= supply_undervoltage_err_i;
            status_o[`AFP_ST_CLK] <= clk_err;
            status_o[`AFP_ST_OC]  <= oc_lat | output_overcurrent_err_i;
            status_o[`AFP_ST_DC]  <= dc_lat | dc_raw;
            status_o[`AFP_ST_OT]  <= ot_lat | die_overtemp_err_i;
        end
    end
endmodule

// [dv/afp_fh_props.sv]
// Assertions on the fault handler ports
`timescale 1ns/100ps
`include "afp_defines.vh"
module afp_fh_props (
    input wire       mclk_i,
    input wire       rst_n_i,
    input wire       amp_shutdown_n_i,
    input wire       sw_shutdown_n_i,
    input wire       supply_overvoltage_err_i,
    input wire       supply_undervoltage_err_i,
    input wire       clk_ratio_bad_i,
    input wire       clk_rate_bad_i,
    input wire       mclk_stopped_i,
    input wire       bclk_stopped_i,
    input wire       fclk_stopped_i,
    input wire       output_overcurrent_err_i,
    input wire       die_overtemp_err_i,
    input wire       amp_fault_n_o,
    input wire       amp_fault_oe_o,
    input wire       play_en_o,
    input wire [5:0] status_o
);
    wire clk_any = clk_ratio_bad_i | clk_rate_bad_i | mclk_stopped_i | bclk_stopped_i
        | fclk_stopped_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire sd_up = amp_shutdown_n_i & sw_shutdown_n_i;
    a_clk_err_low: assert property (clk_any |=> amp_fault_oe_o && status_o[2])
        else $error("Clock error left fault line released");
    a_oc_latch: assert property (output_overcurrent_err_i && sd_up |=> amp_fault_oe_o)
        else $error("Overcurrent not latched");
    a_oc_mute: assert property (output_overcurrent_err_i && sd_up |=> !play_en_o)
        else $error("Overcurrent left playback on");
    a_ot_latch: assert property (die_overtemp_err_i && sd_up |=> amp_fault_oe_o)
        else $error("Overtemperature not latched");
    a_ov_flag: assert property (supply_overvoltage_err_i |=> status_o[0])
        else $error("Overvoltage flag missing");
    a_uv_flag: assert property (supply_undervoltage_err_i |=> status_o[1])
        else $error("Undervoltage flag missing");
    a_oc_flag: assert property (output_overcurrent_err_i |=> status_o[3] && status_o[5] == die_overtemp_err_i || status_o[3])
        else $error("Overcurrent flag missing");
    a_drive_low: assert property (amp_fault_oe_o |-> !amp_fault_n_o)
        else $error("Fault line driven high");
    a_latch_hold: assert property (output_overcurrent_err_i && sd_up ##1 sd_up [*3] |-> amp_fault_oe_o)
        else $error("Latched fault released early");
    c_clk_back: cover property (clk_any ##1 !clk_any ##1 !amp_fault_oe_o);
    c_recover: cover property ($fell(amp_fault_oe_o));
    c_dc_event: cover property ($rose(status_o[4]));
endmodule
bind afp_fault_handler afp_fh_props u_props (.*);

// [dv/afp_sys_ctrl.sv]
// System controller model: drives shutdown, senses the fault line
`timescale 1ns/100ps
module afp_sys_ctrl (
    input  wire mclk_i,
    input  wire amp_fault_oe_i,
    input  wire sd_req_n_i,
    input  wire tie_i,
    output reg  amp_shutdown_n_o,
    output wire fault_line_o
);
    // Pull-up holds line high unless sunk
    assign fault_line_o = !amp_fault_oe_i;
    always @(posedge mclk_i) begin
        amp_shutdown_n_o <= tie_i ? fault_line_o : sd_req_n_i;
    end
endmodule

// [dv/tb_amp_fault_protection_handler.sv]
// Self-checking bench for the fault handler
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("Error %s expected %0h seen %0h", n, e, a); end end
module tb_amp_fault_protection_handler;
    localparam TO = 20;
    localparam DC = 50;
    logic mclk_i = 0, rst_n_i = 0, hw_mode_select_i = 1, sw_swfreq_half_i = 0, hw_swfreq_half_i = 0;
    logic supply_overvoltage_err_i = 0, supply_undervoltage_err_i = 0, pol_a_i = 0, sd_req_n = 1;
    logic sw_shutdown_n_i = 1, tie = 0, pol_b_i = 0;
    logic [6:0] duty_b_pct_i = 0;
    logic output_overcurrent_err_i = 0, die_overtemp_err_i = 0, overtemp_hysteresis_i = 0;
    logic [4:0] cb = 0;
    logic [6:0] duty_a_pct_i = 0;
    wire clk_ratio_bad_i = cb[0], clk_rate_bad_i = cb[1], mclk_stopped_i = cb[2];
    wire bclk_stopped_i = cb[3], fclk_stopped_i = cb[4], amp_shutdown_n_i, fault_line;
    wire amp_fault_n_o, amp_fault_oe_o, play_en_o, swfreq_half_o;
    wire [5:0] status_o;
    int failures = 0, comparisons = 0, cyc = 0;
    afp_fault_handler #(.TIMEOUT_CYCLES(TO), .DC_CYCLES(DC)) dut (.*);
    afp_sys_ctrl u_sys (.mclk_i(mclk_i), .amp_fault_oe_i(amp_fault_oe_o), .sd_req_n_i(sd_req_n),
        .tie_i(tie), .amp_shutdown_n_o(amp_shutdown_n_i), .fault_line_o(fault_line));
    initial begin
        forever #50 mclk_i = !mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            final_report();
        end
    end
    // ====
    // Tasks
    task w(input int n); repeat (n) @(posedge mclk_i); #1; endtask
    task tog(input int n); sd_req_n = 0; w(2 + n); sd_req_n = 1; w(3); endtask
    task final_report();
        $display("Comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task s_nonlatch();
        w(2);
        `CHK("idle line", 1'h1, fault_line)
        supply_overvoltage_err_i = 1; w(2);
        `CHK("ov line", 1'h1, fault_line)
        `CHK("ov play", 1'h0, play_en_o)
        `CHK("ov flag", 1'h1, status_o[0])
        supply_overvoltage_err_i = 0; supply_undervoltage_err_i = 1; w(2);
        `CHK("uv line", 1'h1, fault_line)
        `CHK("uv flag", 1'h1, status_o[1])
        supply_undervoltage_err_i = 0; w(2);
        `CHK("resume", 1'h1, play_en_o)
    endtask
    task s_clock();
        for (int i = 0; i < 5; i++) begin
            cb = 5'h01 << i; w(2);
            `CHK("clk line", 1'h0, fault_line)
            cb = 0; w(2);
            `CHK("clk back", 1'h1, fault_line)
        end
    endtask
    task s_latch();
        output_overcurrent_err_i = 1; w(1); output_overcurrent_err_i = 0; tog(0);
        `CHK("oc early", 1'h1, amp_fault_oe_o)
        w(TO);
        `CHK("oc clear", 6'h00, status_o)
        output_overcurrent_err_i = 1; tog(TO);
        `CHK("relatch", 1'h1, status_o[3])
        output_overcurrent_err_i = 0; tog(TO);
        `CHK("oc off", 1'h0, amp_fault_oe_o)
        die_overtemp_err_i = 1; overtemp_hysteresis_i = 1; w(1); die_overtemp_err_i = 0; tog(TO);
        `CHK("ot hot", 1'h1, amp_fault_oe_o)
        overtemp_hysteresis_i = 0; tog(TO);
        `CHK("ot cool", 1'h0, amp_fault_oe_o)
    endtask
    task s_tie();
        tie = 1; output_overcurrent_err_i = 1; w(1); output_overcurrent_err_i = 0; w(5);
        `CHK("tie sd low", 1'h0, amp_shutdown_n_i)
        w(TO + 5);
        `CHK("tie resume", 1'h1, play_en_o)
        `CHK("tie line", 1'h1, fault_line)
        tie = 0; w(2);
    endtask
    task s_dc();
        duty_a_pct_i = 7'h3C; w(DC + 10);
        `CHK("duty 60", 1'h0, amp_fault_oe_o)
        duty_a_pct_i = 7'h3D; w(DC - 10); pol_a_i = 1; w(DC - 10);
        `CHK("pol flip", 1'h0, amp_fault_oe_o)
        w(15);
        `CHK("dc flag", 1'h1, status_o[4])
        duty_a_pct_i = 0; tog(TO);
        `CHK("dc clear", 1'h1, play_en_o)
        duty_b_pct_i = 7'h50; pol_b_i = 1; w(DC + 5);
        `CHK("dc b flag", 1'h1, status_o[4])
        duty_b_pct_i = 0; tog(TO);
        `CHK("dc b clear", 1'h0, amp_fault_oe_o)
    endtask
    task s_freq();
        sw_swfreq_half_i = 1; w(2);
        `CHK("hw ignores sw", 1'h0, swfreq_half_o)
        rst_n_i = 0; hw_swfreq_half_i = 1; w(2);
        `CHK("rst oe", 1'h0, amp_fault_oe_o)
        `CHK("rst status", 6'h00, status_o)
        rst_n_i = 1; w(2);
        `CHK("hw half", 1'h1, swfreq_half_o)
        rst_n_i = 0; hw_mode_select_i = 0; hw_swfreq_half_i = 0; w(2);
        rst_n_i = 1; w(2);
        `CHK("sw half", 1'h1, swfreq_half_o)
        output_overcurrent_err_i = 1; w(1); output_overcurrent_err_i = 0;
        sw_shutdown_n_i = 0; w(TO + 2); sw_shutdown_n_i = 1; w(3);
        `CHK("sw bit clear", 1'h1, play_en_o)
    endtask
    initial begin
        w(10); rst_n_i = 1;
        s_nonlatch(); s_clock(); s_latch(); s_tie(); s_dc(); s_freq();
        final_report();
    end
endmodule
